// file: bench/prxreg_asserts.sv
/*
 port checker for prxreg_top.
 assumes one clock and the bind below.
*/
`timescale 1ns/1ps
module prxreg_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// framer side
	input wire logic [6:0] devAddr,
	input wire logic byteValid,
	input wire prxreg_pkg::prxreg_byte_t wrByte,
	input wire logic selected,
	// core side
	input wire logic proxIntSet,
	input wire prxreg_pkg::prxreg_cfg_t cfg,
	input wire logic proxIntPending,
	input wire logic proxIntClear
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire cmdOk = selected && byteValid && wrByte.start && wrByte.write;
	wire isClr = wrByte.data inside {8'he5, 8'he7};
	sel_decode_a: assert property (selected == (devAddr == 7'h39))
		else $error("selected wrong");
	clr_cause_a: assert property (cmdOk && isClr |=> proxIntClear)
		else $error("no clear pulse");
	clr_self_a: assert property (proxIntClear |=> !proxIntClear)
		else $error("clear pulse too long");
	noclr_other_a: assert property (cmdOk && !isClr |=> !proxIntClear)
		else $error("clear from other code");
	pend_clr_a: assert property (cmdOk && isClr && !proxIntSet |=> !proxIntPending)
		else $error("pending not cleared");
	pend_set_a: assert property (proxIntSet |=> proxIntPending)
		else $error("pending not set");
	en_write_a: assert property (cmdOk && wrByte.data == 8'h80 ##1
		selected && byteValid && !wrByte.start |=> cfg.enable == $past(wrByte.data))
		else $error("enable not written");
	unsel_a: assert property (!selected |=> $stable(cfg))
		else $error("cfg changed unselected");
endmodule

bind prxreg_top prxreg_asserts i_chk (.clk, .rstn, .devAddr, .byteValid, .wrByte,
	.selected, .proxIntSet, .cfg, .proxIntPending, .proxIntClear);

// file: bench/prxreg_host.sv
/*
 host model feeding the byte framer side of prxreg_top.
 assumes the bench clock; every call drives one cycle from a falling edge.
*/
`timescale 1ns/1ps
module prxreg_host (
	// clock
	input wire logic clk,
	// framer side
	output logic [6:0] devAddr,
	output logic byteValid,
	output prxreg_pkg::prxreg_byte_t wrByte,
	output logic rdReq
);
	initial begin
		devAddr = 7'h39;
		byteValid = 1'b0;
		wrByte = '0;
		rdReq = 1'b0;
	end
	task automatic send(input logic st, input logic [7:0] d);
		@(negedge clk);
		wrByte = '{start: st, write: 1'b1, data: d};
		byteValid = 1'b1;
		rdReq = 1'b0;
	endtask
	task automatic rd();
		@(negedge clk);
		byteValid = 1'b0;
		rdReq = 1'b1;
	endtask
	// released data never keeps its last value
	task automatic idle();
		@(negedge clk);
		byteValid = 1'b0;
		rdReq = 1'b0;
		wrByte.data = ~wrByte.data;
	endtask
endmodule

// file: bench/prxreg_top_tb.sv
/*
 self-checking bench for prxreg_top with the host model.
 assumes the checker is bound in its own file.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin errTotal++; \
	$display("unexpected at %0t: got %h want %h", $time, g, e); end end
module prxreg_top_tb;
	logic clk, rstn, proxIntSet, selected, proxIntPending, proxIntClear, byteValid, rdReq;
	logic seenRd = 1'b0;
	logic inc = 1'b0;
	logic [6:0] devAddr;
	prxreg_pkg::prxreg_byte_t wrByte;
	logic [7:0] rdData, coreStatus, ev;
	logic [15:0] proxResult;
	prxreg_pkg::prxreg_cfg_t cfg;
	logic [7:0] mdl [32];
	logic [7:0] expQ [$];
	logic [4:0] a = 5'h00;
	int errTotal = 0;
	int nCompared = 0;
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	prxreg_host i_host (.clk, .devAddr, .byteValid, .wrByte, .rdReq);
	prxreg_top i_dut (.clk, .rstn, .devAddr, .byteValid, .wrByte, .rdReq, .selected, .rdData,
		.proxResult, .coreStatus, .proxIntSet, .cfg, .proxIntPending, .proxIntClear);
	task automatic completeRun();
		$display("compared %0d, mismatches %0d", nCompared, errTotal);
		if (errTotal == 0 && nCompared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// only types 00, 01 and 11 are ever sent, never the reserved type
	task automatic cmd(input logic [7:0] d);
		i_host.send(1'b1, d);
		if (!d[6]) begin
			a = d[4:0];
			inc = d[5];
		end
	endtask
	task automatic wr(input logic [7:0] d);
		i_host.send(1'b0, d);
		if (a inside {0, 2, 3, [8:15], 30}) mdl[a] = d;
		a = a + 5'(inc);
	endtask
	task automatic rd();
		expQ.push_back(mdl[a]);
		i_host.rd();
		a = a + 5'(inc);
	endtask
	always @(posedge clk) seenRd <= rdReq && selected;
	always @(negedge clk) if (seenRd) begin
		ev = expQ.pop_front();
		`CHK(rdData, ev)
	end
	initial begin
		repeat (5000) @(posedge clk);
		errTotal++;
		completeRun();
	end
	initial begin
		rstn = 1'b0;
		proxIntSet = 1'b0;
		void'($urandom(32'h2f81));
		proxResult = 16'($urandom());
		coreStatus = 8'($urandom()) & 8'hdf;
		mdl = '{default: 8'h00};
		mdl[2] = 8'hff;
		mdl[3] = 8'hff;
		mdl[18] = prxreg_pkg::IDENT_DEFAULT;
		mdl[19] = coreStatus;
		{mdl[25], mdl[24]} = proxResult;
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		cmd(8'ha0);
		repeat (33) rd();
		cmd(8'ha0);
		repeat (32) wr(8'($urandom()));
		cmd(8'ha0);
		repeat (32) rd();
		cmd(8'h88);
		wr(8'($urandom()));
		wr(8'($urandom()));
		rd();
		rd();
		cmd(8'he0);
		rd();
		`CHK(cfg.lowLimit, {mdl[9], mdl[8]})
		i_host.idle();
		i_host.devAddr = 7'h3a;
		i_host.send(1'b1, 8'h80);
		i_host.send(1'b0, ~mdl[0]);
		i_host.idle();
		i_host.devAddr = 7'h39;
		`CHK(cfg.enable, mdl[0])
		cmd(8'h80);
		wr(8'($urandom()));
		i_host.idle();
		`CHK(cfg.enable, mdl[0])
		foreach (mdl[k]) if (k < 4) begin
			proxIntSet = 1'b1;
			i_host.idle();
			proxIntSet = 1'b0;
			// only listed codes: both clears, then the no-action code
			cmd(k[1] ? 8'he0 : (k[0] ? 8'he7 : 8'he5));
			i_host.idle();
			`CHK(proxIntPending, k[1])
		end
		i_host.idle();
		i_host.idle();
		completeRun();
	end
endmodule

// file: hdl/prxreg_cmd.sv
/*
 command byte decoder: splits a command byte into transfer type,
 address and the special-function clear.
 assumes the caller qualifies cmdValid with the command bit.
*/
`timescale 1ns/1ps
module prxreg_cmd (
	// command byte
	input wire logic [7:0] cmdByte,
	input wire logic cmdValid,
	// decoded
	output logic loadAddr,
	output logic [1:0] xferType,
	output logic [4:0] addr,
	output logic proxClear
);
	always_comb begin
		xferType = cmdByte[prxreg_pkg::TYPE_HI:prxreg_pkg::TYPE_LO];
		addr = cmdByte[4:0];
		loadAddr = 1'b0;
		proxClear = 1'b0;
		if (cmdValid) begin
			if (xferType == prxreg_pkg::TYPE_SPECIAL) begin
				// field is a function code, 00000 and reserved codes do nothing
				proxClear = (addr == prxreg_pkg::SF_PCLR_A) || (addr == prxreg_pkg::SF_PCLR_B);
			end else if (xferType == prxreg_pkg::TYPE_REPEAT
					|| xferType == prxreg_pkg::TYPE_AUTOINC) begin
				loadAddr = 1'b1;
			end
		end
	end
endmodule

// file: hdl/prxreg_pkg.sv
/*
 package for the proximity sensor register set: offsets, reset values,
 command byte layout and the byte-stream carrier.
 assumes nothing beyond a SystemVerilog compiler.
*/
package prxreg_pkg;
	// register offsets
	localparam logic [4:0] OFF_ENABLE = 5'h00;
	localparam logic [4:0] OFF_PROX_INTEGRATION_TIME = 5'h02;
	localparam logic [4:0] OFF_WAIT = 5'h03;
	localparam logic [4:0] OFF_LOWL = 5'h08;
	localparam logic [4:0] OFF_LOWH = 5'h09;
	localparam logic [4:0] OFF_HIGHL = 5'h0a;
	localparam logic [4:0] OFF_HIGHH = 5'h0b;
	localparam logic [4:0] OFF_FILTER = 5'h0c;
	localparam logic [4:0] OFF_MISC = 5'h0d;
	localparam logic [4:0] OFF_PULSE = 5'h0e;
	localparam logic [4:0] OFF_GAIN = 5'h0f;
	localparam logic [4:0] OFF_IDENT = 5'h12;
	localparam logic [4:0] OFF_STATUS = 5'h13;
	localparam logic [4:0] OFF_RESL = 5'h18;
	localparam logic [4:0] OFF_RESH = 5'h19;
	localparam logic [4:0] OFF_CORR = 5'h1e;
	// reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_TIME = 8'hff;
	localparam logic [7:0] RST_CORR = 8'h00;
	// arbitrary identity value, not any real part
	localparam logic [7:0] IDENT_DEFAULT = 8'h5a;
	// i2c slave address
	localparam logic [6:0] SLAVE_ADDR = 7'h39;
	// command byte fields
	localparam int CMD_BIT = 7;
	localparam int TYPE_HI = 6;
	localparam int TYPE_LO = 5;
	localparam logic [1:0] TYPE_REPEAT = 2'h0;
	localparam logic [1:0] TYPE_AUTOINC = 2'h1;
	localparam logic [1:0] TYPE_SPECIAL = 2'h3;
	localparam logic [4:0] SF_NOP = 5'h00;
	localparam logic [4:0] SF_PCLR_A = 5'h05;
	localparam logic [4:0] SF_PCLR_B = 5'h07;

	// one byte as delivered by the i2c framer
	typedef struct packed {
		logic start;
		logic write;
		logic [7:0] data;
	} prxreg_byte_t;

	// settings exported to the sensing core
	typedef struct packed {
		logic [7:0] enable;
		logic [7:0] prox_integration_time;
		logic [7:0] waitInterval;
		logic [15:0] lowLimit;
		logic [15:0] highLimit;
		logic [7:0] filterCount;
		logic [7:0] misc;
		logic [7:0] pulseCount;
		logic [7:0] gain;
		logic [7:0] correction;
	} prxreg_cfg_t;
endpackage

// file: hdl/prxreg_top.sv
/*
 register set of the proximity sensor behind an i2c slave byte framer.
 assumes an external framer delivers decoded bytes (start flag on the
 first data byte after the address) and asks for read bytes with rdReq.
*/
`timescale 1ns/1ps
module prxreg_top #(
	parameter logic [7:0] IDENT = prxreg_pkg::IDENT_DEFAULT
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// i2c framer side
	input wire logic [6:0] devAddr,
	input wire logic byteValid,
	input wire prxreg_pkg::prxreg_byte_t wrByte,
	input wire logic rdReq,
	output logic selected,
	output logic [7:0] rdData,
	// sensing core side
	input wire logic [15:0] proxResult,
	input wire logic [7:0] coreStatus,
	input wire logic proxIntSet,
	output prxreg_pkg::prxreg_cfg_t cfg,
	output logic proxIntPending,
	output logic proxIntClear
);
	prxreg_pkg::prxreg_cfg_t cfg_reg, cfg_next;
	logic [4:0] addr_reg, addr_next;
	logic [1:0] type_reg, type_next;
	logic [7:0] rdData_reg, rdData_next;
	logic pend_reg, pend_next;
	logic clr_reg, clr_next;
	logic isCmd, loadAddr, clrCmd;
	logic [1:0] decType;
	logic [4:0] decAddr;
	logic dataWr;

	function automatic logic [7:0] readMux(input logic [4:0] a,
			input prxreg_pkg::prxreg_cfg_t c, input logic [15:0] res,
			input logic [7:0] st, input logic [7:0] idv);
		logic [7:0] v;
		v = 8'h00;
		if (a == prxreg_pkg::OFF_ENABLE) v = c.enable;
		else if (a == prxreg_pkg::OFF_PROX_INTEGRATION_TIME) v = c.prox_integration_time;
		else if (a == prxreg_pkg::OFF_WAIT) v = c.waitInterval;
		else if (a == prxreg_pkg::OFF_LOWL) v = c.lowLimit[7:0];
		else if (a == prxreg_pkg::OFF_LOWH) v = c.lowLimit[15:8];
		else if (a == prxreg_pkg::OFF_HIGHL) v = c.highLimit[7:0];
		else if (a == prxreg_pkg::OFF_HIGHH) v = c.highLimit[15:8];
		else if (a == prxreg_pkg::OFF_FILTER) v = c.filterCount;
		else if (a == prxreg_pkg::OFF_MISC) v = c.misc;
		else if (a == prxreg_pkg::OFF_PULSE) v = c.pulseCount;
		else if (a == prxreg_pkg::OFF_GAIN) v = c.gain;
		else if (a == prxreg_pkg::OFF_IDENT) v = idv;
		else if (a == prxreg_pkg::OFF_STATUS) v = st;
		else if (a == prxreg_pkg::OFF_RESL) v = res[7:0];
		else if (a == prxreg_pkg::OFF_RESH) v = res[15:8];
		else if (a == prxreg_pkg::OFF_CORR) v = c.correction;
		return v;
	endfunction

	assign selected = (devAddr == prxreg_pkg::SLAVE_ADDR);
	// first written byte with bit 7 set is a command, otherwise data
	assign isCmd = selected && byteValid && wrByte.write && wrByte.start
		&& wrByte.data[prxreg_pkg::CMD_BIT];
	assign dataWr = selected && byteValid && wrByte.write && !isCmd;

	prxreg_cmd cmdDec (
		.cmdByte(wrByte.data),
		.cmdValid(isCmd),
		.loadAddr(loadAddr),
		.xferType(decType),
		.addr(decAddr),
		.proxClear(clrCmd)
	);

	always_comb begin
		cfg_next = cfg_reg;
		addr_next = addr_reg;
		type_next = type_reg;
		rdData_next = rdData_reg;
		// hardware set wins over a clear in the same cycle
		pend_next = proxIntSet | (pend_reg & ~clrCmd);
		clr_next = clrCmd;
		if (loadAddr) begin
			addr_next = decAddr;
			type_next = decType;
		end
		if (dataWr) begin
			// unmapped and read-only addresses fall through
			if (addr_reg == prxreg_pkg::OFF_ENABLE) cfg_next.enable = wrByte.data;
			else if (addr_reg == prxreg_pkg::OFF_PROX_INTEGRATION_TIME) cfg_next.prox_integration_time = wrByte.data;
			else if (addr_reg == prxreg_pkg::OFF_WAIT) cfg_next.waitInterval = wrByte.data;
			else if (addr_reg == prxreg_pkg::OFF_LOWL) cfg_next.lowLimit[7:0] = wrByte.data;
			else if (addr_reg == prxreg_pkg::OFF_LOWH) cfg_next.lowLimit[15:8] = wrByte.data;
			else if (addr_reg == prxreg_pkg::OFF_HIGHL) cfg_next.highLimit[7:0] = wrByte.data;
			else if (addr_reg == prxreg_pkg::OFF_HIGHH) cfg_next.highLimit[15:8] = wrByte.data;
			else if (addr_reg == prxreg_pkg::OFF_FILTER) cfg_next.filterCount = wrByte.data;
			else if (addr_reg == prxreg_pkg::OFF_MISC) cfg_next.misc = wrByte.data;
			else if (addr_reg == prxreg_pkg::OFF_PULSE) cfg_next.pulseCount = wrByte.data;
			else if (addr_reg == prxreg_pkg::OFF_GAIN) cfg_next.gain = wrByte.data;
			else if (addr_reg == prxreg_pkg::OFF_CORR) cfg_next.correction = wrByte.data;
		end
		if (selected && rdReq) begin
			// uses addr_reg: the address from the last repeat or auto-increment command, advanced after each access in auto-increment type
			rdData_next = readMux(addr_reg, cfg_reg, proxResult,
				{coreStatus[7:6], pend_reg, coreStatus[4:0]}, IDENT);
		end
		// five-bit address wraps at the top of the map
		if ((dataWr || (selected && rdReq)) && type_reg == prxreg_pkg::TYPE_AUTOINC) begin
			addr_next = addr_reg + 5'h01;
		end
		// repeated-byte type leaves addr_reg as it is
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_reg.enable <= prxreg_pkg::RST_ZERO;
			cfg_reg.prox_integration_time <= prxreg_pkg::RST_TIME;
			cfg_reg.waitInterval <= prxreg_pkg::RST_TIME;
			cfg_reg.lowLimit <= {prxreg_pkg::RST_ZERO, prxreg_pkg::RST_ZERO};
			cfg_reg.highLimit <= {prxreg_pkg::RST_ZERO, prxreg_pkg::RST_ZERO};
			cfg_reg.filterCount <= prxreg_pkg::RST_ZERO;
			cfg_reg.misc <= prxreg_pkg::RST_ZERO;
			cfg_reg.pulseCount <= prxreg_pkg::RST_ZERO;
			cfg_reg.gain <= prxreg_pkg::RST_ZERO;
			cfg_reg.correction <= prxreg_pkg::RST_CORR;
			addr_reg <= 5'h00;
			type_reg <= prxreg_pkg::TYPE_REPEAT;
			rdData_reg <= 8'h00;
			pend_reg <= 1'b0;
			clr_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			addr_reg <= addr_next;
			type_reg <= type_next;
			rdData_reg <= rdData_next;
			pend_reg <= pend_next;
			clr_reg <= clr_next;
		end
	end

	assign cfg = cfg_reg;
	assign rdData = rdData_reg;
	assign proxIntPending = pend_reg;
	assign proxIntClear = clr_reg;
endmodule
